// file: src/spcs_consts.svh
// Purpose: constants of the sleep power chain sequencer
// Assumes: 100 MHz system clock, AHB-Lite register access
// Notes:   delays are plain defaults, shortened through module parameters
//
// Behaviour
// - gated sram cut off, gated radio held reset
// - module clock gates act only active/idle
// - enabled converter stays enabled while sleeping
// - comparator auto-off in deeper sleeps, unless reference
// - fuse-enabled brownout detector off in deep sleep once the chain is off
// - reference powered only on detector/comparator/converter request
// - enabled watchdog keeps running in sleep
// - input buffers off when io and converter clocks stop
// - debug keeps main clock; fuses or bit disable
// - radio stays active during cpu sleep
// - radio inactive when gated or asleep
// - reactivation: oscillator first, then radio idle-off
// - radio reset bit pulses radio reset, self-clears
// - sleep request drives radio sleep line from idle-off
// - power-down/save switches blocks off, wake restores
// - chain powers blocks on one by one in order
// - gated sram blocks and radio steps skipped
// - reset-done only after whole chain enabled
// - start-up time sums the step delays
// - gated peripheral frozen, register access ignored
// - chain stays on while radio ungated and no radio sleep request set
// - debug fuse keeps chain on in all sleeps
`ifndef SPCS_CONSTS_SVH
`define SPCS_CONSTS_SVH
// ==========================================
// register byte offsets
`define SPCS_OFF_GATE_ONE     12'h000
`define SPCS_OFF_GATE_TWO     12'h004
`define SPCS_OFF_RADIO_CTRL   12'h008
`define SPCS_OFF_MCU_CTRL     12'h00C
`define SPCS_OFF_SLEEP_CTRL   12'h010
`define SPCS_OFF_ANALOG_CTRL  12'h014
`define SPCS_OFF_STATUS       12'h018
`define SPCS_OFF_INPUT_DIS0   12'h01C
`define SPCS_OFF_INPUT_DIS1   12'h020
// ==========================================
// field positions
`define SPCS_BIT_RADIO_GATE   5
`define SPCS_BIT_RADIO_RST    0
`define SPCS_BIT_RADIO_SLP    1
`define SPCS_BIT_DEBUG_DIS    7
`define SPCS_BIT_SLEEP_EN     0
`define SPCS_NUM_SRAM         4
// ==========================================
// sleep mode encodings
`define SPCS_SM_IDLE          3'h0
`define SPCS_SM_ADCNR         3'h1
`define SPCS_SM_PDOWN         3'h2
`define SPCS_SM_PSAVE         3'h3
// ==========================================
// timing in ns at a 10 ns clock
`define SPCS_CLK_NS           10
`define SPCS_T_BG_NS          2000
`define SPCS_T_DVREG_NS       2000
`define SPCS_T_DRT_NS         1000
`define SPCS_T_PWRSW_NS       1000
`define SPCS_T_OSC_NS         20000
`define SPCS_CYC(t)           (((t) + `SPCS_CLK_NS - 1) / `SPCS_CLK_NS)
`define SPCS_RST_PULSE        4
`endif

// file: src/spcs_pkg.sv
// Purpose: types of the sleep power chain sequencer
// Assumes: nothing
// Notes:   states carry no codes
package spcs_pkg;
	typedef enum logic [3:0] {
		SPCS_OFF,
		SPCS_BG,
		SPCS_DVREG,
		SPCS_SRAM,
		SPCS_RADIO,
		SPCS_NVM,
		SPCS_OSC,
		SPCS_DONE
	} spcs_chain_type;
endpackage

// file: src/spcs_top.sv
// Purpose: power chain sequencer with sleep gating and radio control
// Assumes: AHB-Lite single word transfers, one clock domain
// Notes:   one wait state on every access, response always OKAY
//
// Local design decisions: the register addresses and the AHB-Lite register port.
`include "spcs_consts.svh"
module spcs_top #(
	parameter int T_BG_CYC    = `SPCS_CYC(`SPCS_T_BG_NS),
	parameter int T_DVREG_CYC = `SPCS_CYC(`SPCS_T_DVREG_NS),
	parameter int T_DRT_CYC   = `SPCS_CYC(`SPCS_T_DRT_NS),
	parameter int T_PWRSW_CYC = `SPCS_CYC(`SPCS_T_PWRSW_NS),
	parameter int T_OSC_CYC   = `SPCS_CYC(`SPCS_T_OSC_NS)
) (
	input  wire logic        CLK_SYS,          // system clock
	input  wire logic        ARST_N,           // async reset, active low
	input  wire logic        HSEL,             // slave select
	input  wire logic [11:0] HADDR,            // byte address
	input  wire logic [1:0]  HTRANS,           // transfer type
	input  wire logic        HWRITE,           // write strobe
	input  wire logic [2:0]  HSIZE,            // transfer size
	input  wire logic [31:0] HWDATA,           // write data
	input  wire logic        HREADY,           // bus ready in
	output logic      [31:0] HRDATA,           // read data
	output logic             HREADYOUT,        // slave ready
	output logic             HRESP,            // response, always okay
	input  wire logic        CPU_SLEEP,        // cpu executed sleep
	input  wire logic        WAKE,             // wake event
	input  wire logic        RADIO_IDLE_OFF,   // radio state field is idle-off
	input  wire logic        ONCHIP_DEBUG_FUSE,// debug fuse programmed
	input  wire logic        SCAN_PORT_FUSE,   // scan port fuse programmed
	input  wire logic        BROWNOUT_FUSE_EN, // brownout level fuses enable
	input  wire logic        WDT_EN,           // watchdog enabled
	input  wire logic        CMP_EN,           // comparator enabled
	input  wire logic        CMP_USES_REF,     // comparator selects reference
	input  wire logic        ADC_EN,           // converter enabled
	output logic      [15:0] MODULE_CLK_EN,    // per-module clock enables
	output logic      [3:0]  SRAM_SW_ON,       // sram retention switches
	output logic             RADIO_RESET,      // radio reset
	output logic             RADIO_SLEEP_LINE, // radio sleep line
	output logic             RADIO_PWR_ON,     // radio power switch
	output logic             OSC16_EN,         // 16 MHz oscillator enable
	output logic             BG_ON,            // bandgap and regulator
	output logic             DVREG_ON,         // digital and low leakage regulators
	output logic             NVM_ON,           // nvm power switch
	output logic             RESET_DONE_OUT,   // chain start-up done
	output logic             MAIN_CLK_EN,      // main clock source running
	output logic             ADC_PWR,          // converter power
	output logic             CMP_PWR,          // comparator power
	output logic             BOD_PWR,          // brownout detector power
	output logic             REF_PWR,          // internal reference power
	output logic             WDT_RUN,          // watchdog runs
	output logic             INBUF_EN,         // digital input buffers
	output logic             REG_BLOCKED       // gated peripheral access ignored
);
	// ==========================================
	// registers
	logic [7:0]  module_gate_reg_one;
	logic [7:0]  module_gate_reg_two;
	logic [7:0]  mcu_control_reg;
	logic [2:0]  sleep_mode;
	logic        sleep_en;
	logic [7:0]  input_disable_reg_zero;
	logic [7:0]  input_disable_reg_one;
	logic        radio_sleep_request;
	logic [2:0]  rst_cnt;
	logic        dp_valid;
	logic        dp_write;
	logic [11:0] dp_addr;
	logic        asleep;
	spcs_pkg::spcs_chain_type state;
	spcs_pkg::spcs_chain_type next_state;
	logic [31:0] cnt;
	logic [1:0]  sram_idx;
	logic        deep;
	logic        radio_gate_bit;
	logic        debug_on;
	logic        clocks_run;
	logic        io_adc_stopped;
	logic        chain_may_off;
	logic [31:0] rdata;

	assign radio_gate_bit = module_gate_reg_one[`SPCS_BIT_RADIO_GATE];
	assign debug_on = ONCHIP_DEBUG_FUSE & SCAN_PORT_FUSE & ~mcu_control_reg[`SPCS_BIT_DEBUG_DIS];
	assign deep = asleep & ((sleep_mode == `SPCS_SM_PDOWN) | (sleep_mode == `SPCS_SM_PSAVE));
	assign clocks_run = ~asleep | (sleep_mode == `SPCS_SM_IDLE);
	assign io_adc_stopped = asleep & (sleep_mode != `SPCS_SM_IDLE) & (sleep_mode != `SPCS_SM_ADCNR);
	// radio off-state lets the chain drop; debug fuse pins it on
	assign chain_may_off = deep & (radio_gate_bit | radio_sleep_request)
		& ~ONCHIP_DEBUG_FUSE;

	function automatic logic sram_on(input logic [7:0] gate, input logic [1:0] idx);
		sram_on = ~gate[idx];
	endfunction

	// ==========================================
	// AHB-Lite slave, one wait state
	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			dp_valid <= 1'b0;
			dp_write <= 1'b0;
			dp_addr <= 12'h000;
			HREADYOUT <= 1'b1;
		end else if (dp_valid) begin
			dp_valid <= 1'b0;
			HREADYOUT <= 1'b1;
		end else if (HSEL && HREADY && HTRANS[1]) begin
			dp_valid <= 1'b1;
			dp_write <= HWRITE;
			dp_addr <= HADDR;
			HREADYOUT <= 1'b0;
		end
	end

	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			HRESP <= 1'b0;
		end else begin
			HRESP <= 1'b0;
		end
	end

	always_comb begin
		rdata = 32'h0000_0000;
		case (dp_addr)
			`SPCS_OFF_GATE_ONE:    rdata = {24'h000000, module_gate_reg_one};
			`SPCS_OFF_GATE_TWO:    rdata = {24'h000000, module_gate_reg_two};
			`SPCS_OFF_RADIO_CTRL:  rdata = {30'h00000000, radio_sleep_request, 1'b0};
			`SPCS_OFF_MCU_CTRL:    rdata = {24'h000000, mcu_control_reg};
			`SPCS_OFF_SLEEP_CTRL:  rdata = {28'h0000000, sleep_mode, sleep_en};
			`SPCS_OFF_STATUS:      rdata = {23'h000000, asleep, RESET_DONE_OUT, SRAM_SW_ON,
				RADIO_PWR_ON, NVM_ON, DVREG_ON};
			`SPCS_OFF_INPUT_DIS0:  rdata = {24'h000000, input_disable_reg_zero};
			`SPCS_OFF_INPUT_DIS1:  rdata = {24'h000000, input_disable_reg_one};
			default:               rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			HRDATA <= 32'h0000_0000;
		end else if (dp_valid && !dp_write) begin
			HRDATA <= rdata;
		end
	end

	// ==========================================
	// software writes
	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			module_gate_reg_one <= 8'h00;
			module_gate_reg_two <= 8'h00;
			mcu_control_reg <= 8'h00;
			sleep_mode <= 3'h0;
			sleep_en <= 1'b0;
			input_disable_reg_zero <= 8'h00;
			input_disable_reg_one <= 8'h00;
			radio_sleep_request <= 1'b0;
		end else if (dp_valid && dp_write) begin
			case (dp_addr)
				`SPCS_OFF_GATE_ONE:   module_gate_reg_one <= HWDATA[7:0];
				`SPCS_OFF_GATE_TWO:   module_gate_reg_two <= HWDATA[7:0];
				`SPCS_OFF_RADIO_CTRL: radio_sleep_request <= HWDATA[`SPCS_BIT_RADIO_SLP];
				`SPCS_OFF_MCU_CTRL:   mcu_control_reg <= HWDATA[7:0];
				`SPCS_OFF_SLEEP_CTRL: begin
					sleep_mode <= HWDATA[3:1];
					sleep_en <= HWDATA[`SPCS_BIT_SLEEP_EN];
				end
				`SPCS_OFF_INPUT_DIS0: input_disable_reg_zero <= HWDATA[7:0];
				`SPCS_OFF_INPUT_DIS1: input_disable_reg_one <= HWDATA[7:0];
				default: begin
				end
			endcase
		end
	end

	// radio reset pulse; self-clearing, reads back zero
	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			rst_cnt <= 3'h0;
		end else if (dp_valid && dp_write && dp_addr == `SPCS_OFF_RADIO_CTRL
				&& HWDATA[`SPCS_BIT_RADIO_RST]) begin
			rst_cnt <= 3'(`SPCS_RST_PULSE);
		end else if (rst_cnt != 3'h0) begin
			rst_cnt <= rst_cnt - 3'h1;
		end
	end

	// ==========================================
	// sleep state: entry while enabled, left on wake
	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			asleep <= 1'b0;
		end else if (WAKE) begin
			asleep <= 1'b0;
		end else if (CPU_SLEEP && sleep_en && state == spcs_pkg::SPCS_DONE) begin
			asleep <= 1'b1;
		end
	end

	// ==========================================
	// power chain sequencer
	always_comb begin
		next_state = state;
		case (state)
			spcs_pkg::SPCS_OFF:   next_state = spcs_pkg::SPCS_BG;
			spcs_pkg::SPCS_BG:    if (cnt == 32'd0) next_state = spcs_pkg::SPCS_DVREG;
			spcs_pkg::SPCS_DVREG: if (cnt == 32'd0) next_state = spcs_pkg::SPCS_SRAM;
			spcs_pkg::SPCS_SRAM:  if (cnt == 32'd0 && sram_idx == 2'd3)
				next_state = spcs_pkg::SPCS_RADIO;
			spcs_pkg::SPCS_RADIO: if (cnt == 32'd0) next_state = spcs_pkg::SPCS_NVM;
			spcs_pkg::SPCS_NVM:   if (cnt == 32'd0) next_state = spcs_pkg::SPCS_OSC;
			spcs_pkg::SPCS_OSC:   if (cnt == 32'd0) next_state = spcs_pkg::SPCS_DONE;
			spcs_pkg::SPCS_DONE:  if (chain_may_off) next_state = spcs_pkg::SPCS_OFF;
			default:              next_state = spcs_pkg::SPCS_OFF;
		endcase
		if (state == spcs_pkg::SPCS_OFF && deep && !WAKE) begin
			next_state = spcs_pkg::SPCS_OFF;
		end
	end

	// each step loads its settling delay; skipped steps load zero
	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			state <= spcs_pkg::SPCS_OFF;
			cnt <= 32'd0;
			sram_idx <= 2'd0;
		end else begin
			state <= next_state;
			if (state != next_state || (state == spcs_pkg::SPCS_SRAM && cnt == 32'd0)) begin
				sram_idx <= (state == spcs_pkg::SPCS_SRAM && next_state == state) ?
					sram_idx + 2'd1 : 2'd0;
			end
			if (cnt != 32'd0) begin
				cnt <= cnt - 32'd1;
			end else begin
				case (next_state)
					spcs_pkg::SPCS_BG:    cnt <= 32'(T_BG_CYC);
					spcs_pkg::SPCS_DVREG: cnt <= 32'(T_DVREG_CYC);
					spcs_pkg::SPCS_SRAM: begin
						if (sram_on(module_gate_reg_two, (state == next_state) ?
								sram_idx + 2'd1 : 2'd0))
							cnt <= 32'(T_DRT_CYC);
						else
							cnt <= 32'd0;
					end
					spcs_pkg::SPCS_RADIO: cnt <= radio_gate_bit ? 32'd0 : 32'(T_PWRSW_CYC);
					spcs_pkg::SPCS_NVM:   cnt <= 32'(T_PWRSW_CYC);
					spcs_pkg::SPCS_OSC:   cnt <= 32'(T_OSC_CYC);
					default:              cnt <= 32'd0;
				endcase
			end
		end
	end

	// switch outputs follow the chain position
	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			BG_ON <= 1'b0;
			DVREG_ON <= 1'b0;
			SRAM_SW_ON <= 4'h0;
			RADIO_PWR_ON <= 1'b0;
			NVM_ON <= 1'b0;
			OSC16_EN <= 1'b0;
			RESET_DONE_OUT <= 1'b0;
		end else begin
			BG_ON <= (next_state != spcs_pkg::SPCS_OFF);
			DVREG_ON <= (next_state > spcs_pkg::SPCS_BG);
			for (int i = 0; i < `SPCS_NUM_SRAM; i++) begin
				SRAM_SW_ON[i] <= sram_on(module_gate_reg_two, 2'(i))
					&& ((next_state > spcs_pkg::SPCS_SRAM)
					|| (next_state == spcs_pkg::SPCS_SRAM && 2'(i) <= sram_idx));
			end
			RADIO_PWR_ON <= ~radio_gate_bit && next_state >= spcs_pkg::SPCS_RADIO;
			NVM_ON <= (next_state >= spcs_pkg::SPCS_NVM);
			OSC16_EN <= (next_state >= spcs_pkg::SPCS_OSC);
			RESET_DONE_OUT <= (next_state == spcs_pkg::SPCS_DONE);
		end
	end

	// ==========================================
	// radio control: reset held while gated or pulsed, released after oscillator
	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			RADIO_RESET <= 1'b1;
			RADIO_SLEEP_LINE <= 1'b0;
		end else begin
			// follows next_state so reset and reset-done move on the same edge
			RADIO_RESET <= radio_gate_bit || rst_cnt != 3'h0
				|| next_state != spcs_pkg::SPCS_DONE;
			// sleep only taken from idle-off; line drops when the request bit clears
			if (!radio_sleep_request)
				RADIO_SLEEP_LINE <= 1'b0;
			else if (RADIO_IDLE_OFF)
				RADIO_SLEEP_LINE <= 1'b1;
		end
	end

	// ==========================================
	// sleep effects on helpers
	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			MODULE_CLK_EN <= 16'hFFFF;
			REG_BLOCKED <= 1'b0;
			MAIN_CLK_EN <= 1'b1;
			ADC_PWR <= 1'b0;
			CMP_PWR <= 1'b0;
			BOD_PWR <= 1'b0;
			REF_PWR <= 1'b0;
			WDT_RUN <= 1'b0;
			INBUF_EN <= 1'b1;
		end else begin
			// gating only matters while clocks run; stopped clocks stay stopped
			MODULE_CLK_EN <= clocks_run ? ~{module_gate_reg_two, module_gate_reg_one}
				: 16'h0000;
			REG_BLOCKED <= |{module_gate_reg_two, module_gate_reg_one};
			MAIN_CLK_EN <= ~asleep | debug_on | (sleep_mode == `SPCS_SM_IDLE);
			ADC_PWR <= ADC_EN;
			CMP_PWR <= CMP_EN & (~io_adc_stopped | CMP_USES_REF);
			BOD_PWR <= BROWNOUT_FUSE_EN & ~(deep && state == spcs_pkg::SPCS_OFF);
			REF_PWR <= ADC_EN | (CMP_EN & (~io_adc_stopped | CMP_USES_REF))
				| (BROWNOUT_FUSE_EN & ~(deep && state == spcs_pkg::SPCS_OFF));
			WDT_RUN <= WDT_EN;
			INBUF_EN <= ~io_adc_stopped;
		end
	end
endmodule

// file: verification/spcs_assertions.sv
// Purpose: port assertions of the sleep power chain sequencer
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   bound to spcs_top at the foot of this file
module spcs_assertions #(
	parameter int T_BG_CYC    = 2,
	parameter int T_PWRSW_CYC = 2,
	parameter int T_OSC_CYC   = 2
) (
	input wire logic       CLK_SYS,          // clock
	input wire logic       ARST_N,           // reset
	input wire logic       HSEL,             // select
	input wire logic [1:0] HTRANS,           // transfer type
	input wire logic       HREADY,           // ready in
	input wire logic       HREADYOUT,        // ready out
	input wire logic       WDT_EN,           // watchdog enabled
	input wire logic       RADIO_IDLE_OFF,   // radio idle-off
	input wire logic       RADIO_RESET,      // radio reset
	input wire logic       RADIO_SLEEP_LINE, // radio sleep
	input wire logic       OSC16_EN,         // oscillator
	input wire logic       BG_ON,            // bandgap
	input wire logic       DVREG_ON,         // regulators
	input wire logic       NVM_ON,           // nvm switch
	input wire logic       RESET_DONE_OUT,   // chain done
	input wire logic       ADC_PWR,          // converter
	input wire logic       CMP_PWR,          // comparator
	input wire logic       BOD_PWR,          // brownout
	input wire logic       REF_PWR,          // reference
	input wire logic       WDT_RUN           // watchdog runs
);
	timeunit 1ns;
	timeprecision 1ns;
	// slack for the few extra cycles that the oscillator step may take before done
	localparam int OSC_MAX = T_OSC_CYC + 8;
	default clocking @(posedge CLK_SYS);
	endclocking
	default disable iff (!ARST_N);
	// ==========================================
	// bus and chain
	a_wait_state: assert property (HSEL && HREADY && HTRANS[1] |=> !HREADYOUT ##1 HREADYOUT)
		else $error("bus wait state wrong");
	a_held_reset: assert property (!RESET_DONE_OUT |-> RADIO_RESET)
		else $error("radio out of reset before chain done");
	a_done_chain: assert property (RESET_DONE_OUT |-> BG_ON && DVREG_ON && NVM_ON)
		else $error("done while chain incomplete");
	a_dvreg_delay: assert property ($rose(DVREG_ON) |-> $past(BG_ON, T_BG_CYC))
		else $error("regulator before bandgap settled");
	a_osc_delay: assert property ($rose(OSC16_EN) |-> $past(NVM_ON, T_PWRSW_CYC))
		else $error("oscillator before nvm settled");
	a_done_delay: assert property ($rose(RESET_DONE_OUT) |-> $past(OSC16_EN, T_OSC_CYC))
		else $error("done before oscillator start-up");
	a_done_bound: assert property ($rose(OSC16_EN) |-> ##[1:OSC_MAX] RESET_DONE_OUT)
		else $error("done late after oscillator");
	// ==========================================
	// radio and analog helpers
	a_radio_after: assert property ($fell(RADIO_RESET) |-> OSC16_EN)
		else $error("radio started without oscillator");
	a_reset_pulse: assert property ($rose(RADIO_RESET) |-> RADIO_RESET [*4])
		else $error("radio reset pulse short");
	a_sleep_line: assert property ($rose(RADIO_SLEEP_LINE) |-> $past(RADIO_IDLE_OFF))
		else $error("sleep line raised outside idle-off");
	a_wdt_runs: assert property (WDT_EN [*3] |-> WDT_RUN)
		else $error("enabled watchdog stopped");
	a_ref_needed: assert property (REF_PWR |-> BOD_PWR || CMP_PWR || ADC_PWR
		|| $past(BOD_PWR || CMP_PWR || ADC_PWR))
		else $error("reference on without request");
endmodule
bind spcs_top spcs_assertions #(.T_BG_CYC(T_BG_CYC), .T_PWRSW_CYC(T_PWRSW_CYC),
	.T_OSC_CYC(T_OSC_CYC)) u_chk (.CLK_SYS, .ARST_N, .HSEL, .HTRANS, .HREADY,
	.HREADYOUT, .WDT_EN, .RADIO_IDLE_OFF, .RADIO_RESET, .RADIO_SLEEP_LINE, .OSC16_EN,
	.BG_ON, .DVREG_ON, .NVM_ON, .RESET_DONE_OUT, .ADC_PWR, .CMP_PWR, .BOD_PWR,
	.REF_PWR, .WDT_RUN);

// file: verification/spcs_partner.sv
// Purpose: cpu core and radio state model beside the sequencer
// Assumes: bench sleep and wake requests arrive as one-cycle pulses
// Notes:   idle-off is only reported once the radio leaves reset
module spcs_partner (
	input  wire logic CLK_SYS,        // clock
	input  wire logic ARST_N,         // reset
	input  wire logic sleep_go,       // cpu runs its sleep
	input  wire logic wake_go,        // wake event
	input  wire logic idle_req,       // radio settles idle-off
	input  wire logic RADIO_RESET,    // radio reset
	output logic      CPU_SLEEP,      // sleep executed
	output logic      WAKE,           // wake
	output logic      RADIO_IDLE_OFF  // radio state
);
	timeunit 1ns;
	timeprecision 1ns;
	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			CPU_SLEEP <= 1'b0;
			WAKE <= 1'b0;
			RADIO_IDLE_OFF <= 1'b0;
		end else begin
			CPU_SLEEP <= sleep_go;
			WAKE <= wake_go;
			RADIO_IDLE_OFF <= idle_req && !RADIO_RESET;
		end
	end
endmodule

// file: verification/testbench.sv
// Purpose: self-checking bench of the sleep power chain sequencer
// Assumes: shortened chain delays, one AHB-Lite master
// Notes:   table rows cover registers, hand tests cover sleep and chain
`include "spcs_consts.svh"
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin n_mismatch++; \
	$display("wrong value %s exp %0h got %0h", n, e, a); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int TB = 3, TD = 3, TR = 2, TP = 2, TO = 4;
	localparam int TW = TB + TD + 2 * TR + 2 * TP + TO;
	typedef struct packed {logic [11:0] a; logic [7:0] d; logic [7:0] e;} spcs_row_type;
	logic        CLK_SYS, ARST_N, HSEL, HWRITE, HREADY, HRESP, HREADYOUT;
	logic [11:0] HADDR;
	logic [1:0]  HTRANS;
	logic [2:0]  HSIZE;
	logic [31:0] HWDATA, HRDATA, r;
	logic        CPU_SLEEP, WAKE, RADIO_IDLE_OFF, ONCHIP_DEBUG_FUSE, SCAN_PORT_FUSE;
	logic        BROWNOUT_FUSE_EN, WDT_EN, CMP_EN, CMP_USES_REF, ADC_EN, RADIO_RESET;
	logic [15:0] MODULE_CLK_EN;
	logic [3:0]  SRAM_SW_ON;
	logic        RADIO_SLEEP_LINE, RADIO_PWR_ON, OSC16_EN, BG_ON, DVREG_ON, NVM_ON;
	logic        RESET_DONE_OUT, MAIN_CLK_EN, ADC_PWR, CMP_PWR, BOD_PWR, REF_PWR;
	logic        WDT_RUN, INBUF_EN, REG_BLOCKED, sleep_go, wake_go, idle_req;
	int          n_mismatch, checks, c;
	spcs_row_type rows [8] = '{'{12'h000, 8'h00, 8'h00}, '{12'h00C, 8'h80, 8'h80},
		'{12'h00C, 8'h00, 8'h00}, '{12'h014, 8'hFF, 8'h00}, '{12'h030, 8'hFF, 8'h00},
		'{12'h01C, 8'h3C, 8'h3C}, '{12'h020, 8'h81, 8'h81}, '{12'h008, 8'h01, 8'h00}};
	assign HREADY = HREADYOUT;
	spcs_top #(.T_BG_CYC(TB), .T_DVREG_CYC(TD), .T_DRT_CYC(TR), .T_PWRSW_CYC(TP),
		.T_OSC_CYC(TO)) i_dut (.CLK_SYS, .ARST_N, .HSEL, .HADDR, .HTRANS, .HWRITE,
		.HSIZE, .HWDATA, .HREADY, .HRDATA, .HREADYOUT, .HRESP, .CPU_SLEEP, .WAKE,
		.RADIO_IDLE_OFF, .ONCHIP_DEBUG_FUSE, .SCAN_PORT_FUSE, .BROWNOUT_FUSE_EN, .WDT_EN,
		.CMP_EN, .CMP_USES_REF, .ADC_EN, .MODULE_CLK_EN, .SRAM_SW_ON, .RADIO_RESET,
		.RADIO_SLEEP_LINE, .RADIO_PWR_ON, .OSC16_EN, .BG_ON, .DVREG_ON, .NVM_ON,
		.RESET_DONE_OUT, .MAIN_CLK_EN, .ADC_PWR, .CMP_PWR, .BOD_PWR, .REF_PWR, .WDT_RUN,
		.INBUF_EN, .REG_BLOCKED);
	spcs_partner i_cpu (.CLK_SYS, .ARST_N, .sleep_go, .wake_go, .idle_req, .RADIO_RESET,
		.CPU_SLEEP, .WAKE, .RADIO_IDLE_OFF);
	always #5 CLK_SYS = ~CLK_SYS;
	// ==========================================
	// tasks
	task automatic final_report;
		$display("mismatches %0d checks %0d", n_mismatch, checks);
		if (n_mismatch == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic limit(input int n);
		if (n >= 400) begin
			n_mismatch++;
			final_report();
		end
	endtask
	// request held until ready is seen high at an edge
	task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
		int n;
		n = 0;
		HADDR <= a;
		HWRITE <= w;
		HTRANS <= 2'h2;
		do begin
			@(posedge CLK_SYS);
			n++;
		end while (HREADYOUT !== 1'b1 && n < 400);
		HTRANS <= 2'h0;
		HWDATA <= {24'h000000, d};
		do begin
			@(posedge CLK_SYS);
			n++;
		end while (HREADYOUT !== 1'b1 && n < 400);
		r = HRDATA;
		limit(n);
	endtask
	task automatic wait_for(input logic v);
		c = 0;
		while (RESET_DONE_OUT !== v && c < 400) begin
			@(posedge CLK_SYS);
			c++;
		end
		limit(c);
	endtask
	task automatic cpu(input logic s);
		sleep_go <= s;
		wake_go <= !s;
		@(posedge CLK_SYS);
		sleep_go <= 1'b0;
		wake_go <= 1'b0;
		repeat (8) @(posedge CLK_SYS);
	endtask
	// ==========================================
	// sequence
	initial begin
		CLK_SYS = 1'b0;
		ARST_N = 1'b0;
		HSEL = 1'b1;
		HADDR = 12'h000;
		HTRANS = 2'h0;
		HWRITE = 1'b0;
		HSIZE = 3'h2;
		HWDATA = 32'h00000000;
		{sleep_go, wake_go, idle_req, ONCHIP_DEBUG_FUSE, SCAN_PORT_FUSE} = 5'h00;
		{BROWNOUT_FUSE_EN, WDT_EN, CMP_EN, CMP_USES_REF, ADC_EN} = 5'h1D;
		n_mismatch = 0;
		checks = 0;
		repeat (2) @(posedge CLK_SYS);
		`CHK("reset ready", 1'b1, HREADYOUT)
		`CHK("reset radio", 1'b1, RADIO_RESET)
		`CHK("reset clocks", 16'hFFFF, MODULE_CLK_EN)
		ARST_N <= 1'b1;
		wait_for(1'b1);
		`CHK("start-up", 1'b1, c >= TB+TD+4*TR+3*TP+TO && c <= TB+TD+4*TR+3*TP+TO+24)
		`CHK("sram on", 4'hF, SRAM_SW_ON)
		$display("test power-up done");
		foreach (rows[i]) begin
			bus(1'b1, rows[i].a, rows[i].d);
			bus(1'b0, rows[i].a, 8'h00);
			`CHK("read back", {24'h000000, rows[i].e}, r)
			`CHK("bus response", 1'b0, HRESP)
		end
		$display("test register table done");
		bus(1'b1, `SPCS_OFF_GATE_TWO, 8'h0A);
		bus(1'b1, `SPCS_OFF_GATE_ONE, 8'h20);
		bus(1'b1, `SPCS_OFF_SLEEP_CTRL, 8'h01);
		cpu(1'b1);
		`CHK("sram gated", 4'h5, SRAM_SW_ON)
		`CHK("radio gated", 1'b1, RADIO_RESET)
		`CHK("idle clocks", 16'hF5DF, MODULE_CLK_EN)
		`CHK("idle comparator", 1'b1, CMP_PWR)
		`CHK("gate blocked", 1'b1, REG_BLOCKED)
		cpu(1'b0);
		bus(1'b1, `SPCS_OFF_SLEEP_CTRL, 8'h03);
		cpu(1'b1);
		`CHK("adcnr buffers", 1'b1, INBUF_EN)
		`CHK("adcnr comparator", 1'b1, CMP_PWR)
		`CHK("adcnr clocks", 16'h0000, MODULE_CLK_EN)
		cpu(1'b0);
		$display("test gating and idle done");
		ONCHIP_DEBUG_FUSE <= 1'b1;
		SCAN_PORT_FUSE <= 1'b1;
		bus(1'b1, `SPCS_OFF_SLEEP_CTRL, 8'h05);
		cpu(1'b1);
		`CHK("debug chain", 1'b1, NVM_ON)
		`CHK("debug clock", 1'b1, MAIN_CLK_EN)
		`CHK("sleep clocks", 16'h0000, MODULE_CLK_EN)
		`CHK("sleep comparator", 1'b0, CMP_PWR)
		`CHK("sleep converter", 1'b1, ADC_PWR)
		`CHK("sleep watchdog", 1'b1, WDT_RUN)
		`CHK("sleep buffers", 1'b0, INBUF_EN)
		SCAN_PORT_FUSE <= 1'b0;
		CMP_USES_REF <= 1'b1;
		repeat (2) @(posedge CLK_SYS);
		`CHK("scan fuse clock", 1'b0, MAIN_CLK_EN)
		`CHK("ref comparator", 1'b1, CMP_PWR)
		SCAN_PORT_FUSE <= 1'b1;
		CMP_USES_REF <= 1'b0;
		bus(1'b1, `SPCS_OFF_MCU_CTRL, 8'h80);
		@(posedge CLK_SYS);
		`CHK("debug bit clock", 1'b0, MAIN_CLK_EN)
		bus(1'b1, `SPCS_OFF_MCU_CTRL, 8'h00);
		cpu(1'b0);
		ONCHIP_DEBUG_FUSE <= 1'b0;
		CMP_EN <= 1'b0;
		ADC_EN <= 1'b0;
		cpu(1'b1);
		wait_for(1'b0);
		`CHK("deep bandgap", 1'b0, BG_ON)
		`CHK("deep nvm", 1'b0, NVM_ON)
		`CHK("deep brownout", 1'b0, BOD_PWR)
		`CHK("deep reference", 1'b0, REF_PWR)
		`CHK("deep clock", 1'b0, MAIN_CLK_EN)
		cpu(1'b0);
		wait_for(1'b1);
		`CHK("wake time", 1'b1, c + 9 >= TW && c + 9 <= TW + 24)
		`CHK("wake sram", 4'h5, SRAM_SW_ON)
		`CHK("wake radio", 1'b0, RADIO_PWR_ON)
		$display("test deep sleep done");
		bus(1'b1, `SPCS_OFF_GATE_ONE, 8'h00);
		cpu(1'b1);
		`CHK("radio keeps chain", 1'b1, NVM_ON)
		`CHK("radio active", 1'b0, RADIO_RESET)
		cpu(1'b0);
		bus(1'b1, `SPCS_OFF_RADIO_CTRL, 8'h02);
		repeat (4) @(posedge CLK_SYS);
		`CHK("line not idle", 1'b0, RADIO_SLEEP_LINE)
		idle_req <= 1'b1;
		repeat (4) @(posedge CLK_SYS);
		`CHK("line idle", 1'b1, RADIO_SLEEP_LINE)
		cpu(1'b1);
		wait_for(1'b0);
		`CHK("asleep radio", 1'b0, NVM_ON)
		cpu(1'b0);
		wait_for(1'b1);
		bus(1'b1, `SPCS_OFF_RADIO_CTRL, 8'h00);
		repeat (4) @(posedge CLK_SYS);
		`CHK("line cleared", 1'b0, RADIO_SLEEP_LINE)
		$display("test radio sleep done");
		final_report();
	end
endmodule
